// >>> logic/wdt_pkg.sv
// shared constants, register map and decode helpers for the keyed watchdog
package wdt_pkg;

  // ==========================================================
  // counter and bus widths
  localparam int unsigned COUNT_W = 18;
  localparam int unsigned ADR_W = 8;
  localparam int unsigned DAT_W = 32;

  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_FLAGS = 6'h01;
  localparam logic [5:0] IDX_SUBCFG = 6'h02;
  localparam logic [5:0] IDX_STATUS = 6'h03;

  // ==========================================================
  // field layout of watchdog_control
  localparam int KEY_HI = 7;
  localparam int KEY_LO = 3;
  localparam int SEL_HI = 2;
  localparam int SEL_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h53;
  localparam logic [4:0] KEY_DISABLE = 5'h15;
  localparam logic [4:0] KEY_ENABLE = 5'h0a;

  // ==========================================================
  // bit positions of the flag, config and status words
  localparam int FLAG_KEY = 0;
  localparam int FLAG_VSEL = 1;
  localparam int FLAG_LV = 2;
  localparam int SUBCFG_SRC = 0;
  localparam int STAT_TO = 0;
  localparam int STAT_PDF = 1;
  localparam logic SUBCFG_RESET = 1'b0;

  // ==========================================================
  // pin synchroniser slots and their idle levels
  localparam int PIN_COUNT = 3;
  localparam int PIN_LXT = 0;
  localparam int PIN_LOW_SPEED_INTERNAL_RC = 1;
  localparam int PIN_RESN = 2;
  localparam logic [2:0] SYNC_RESET = 3'h4;

  // last count before overflow for each timeout select code
  function automatic logic [COUNT_W-1:0] timeoutLimit(input logic [2:0] sel);
    case (sel)
      3'h0: timeoutLimit = 18'h000ff;
      3'h1: timeoutLimit = 18'h003ff;
      3'h2: timeoutLimit = 18'h00fff;
      3'h3: timeoutLimit = 18'h03fff;
      3'h4: timeoutLimit = 18'h07fff;
      3'h5: timeoutLimit = 18'h0ffff;
      3'h6: timeoutLimit = 18'h1ffff;
      default: timeoutLimit = 18'h3ffff;
    endcase
  endfunction : timeoutLimit

  // true when the key field holds neither the enable nor the disable code
  function automatic logic keyInvalid(input logic [4:0] key);
    keyInvalid = (key != KEY_ENABLE) && (key != KEY_DISABLE);
  endfunction : keyInvalid

endpackage : wdt_pkg

// >>> logic/wdt_count_if.sv
// link between the watchdog control logic and its sub clock counter
`timescale 1ns/1ps
interface wdt_count_if;
  import wdt_pkg::*;
  logic subTick;
  logic clearCount;
  logic runCount;
  logic [2:0] timeoutSelect;
  logic overflow;
  modport ctrl (output subTick, clearCount, runCount, timeoutSelect, input overflow);
  modport counter (input subTick, clearCount, runCount, timeoutSelect, output overflow);
endinterface : wdt_count_if

// >>> logic/sub_clock_counter.sv
// sub clock tick counter with selectable overflow length
`timescale 1ns/1ps
module sub_clock_counter
  import wdt_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  wdt_count_if.counter cnt // control side
);

  logic [COUNT_W-1:0] count_reg;
  logic overflow_reg;

  // ==========================================================
  // count sub clock ticks, clear has priority over everything
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (cnt.clearCount || !cnt.runCount) begin
      count_reg <= '0;
    end else if (cnt.subTick) begin
      if (count_reg >= timeoutLimit(cnt.timeoutSelect)) begin
        count_reg <= '0;
      end else begin
        count_reg <= count_reg + 18'h00001;
      end
    end
  end

  // one-cycle overflow pulse on the tick that ends the period
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      overflow_reg <= 1'b0;
    end else begin
      overflow_reg <= cnt.runCount && !cnt.clearCount && cnt.subTick
        && (count_reg >= timeoutLimit(cnt.timeoutSelect));
    end
  end

  assign cnt.overflow = overflow_reg;

endmodule : sub_clock_counter

// >>> logic/keyed_watchdog_timer.sv
// keyed watchdog timer with wishbone register access
//
// How it works
// - The counter advances on rising edges of the sub clock, picked from crystal or RC pin by a select bit.
// - The timeout select code chooses an overflow after 2^8, 2^10, 2^12, 2^14, 2^15, 2^16, 2^17 or 2^18 sub clock cycles.
// - A key of 10101b turns the watchdog off and a key of 01010b turns it on.
// - Any other key pattern fires a full reset two to three sub clock cycles later.
// - A reset from a bad key sets the key reset flag in bit 0 of the reset cause word.
// - Hardware never clears the key reset flag; software writes zero to clear it after handling it.
// - After power-on the control register holds key 01010b and timeout code 011.
// - In normal running an overflow requests a device reset and sets the time-out flag.
// - An overflow in sleep or idle sets time-out and power-down and asks only for a program counter reset.
// - The core keeps the counter from overflowing with the clear-watchdog instruction, one of several sources that clear it.
// - A halt, a bad-key reset and a low external reset pin also clear the counter.
// - Power-down is cleared by power-up or clear-watchdog and set by every halt.
// - A sleep overflow gives a wake reset while the pin gives a full reset, told apart by the two flags.
// - The control register holds the key in bits 7..3 and the timeout select in bits 2..0, all read-write.
// - Bits 7..3 of the reset cause word read as zero.
// - Entering sleep or idle clears the counter, which then runs only if enabled.
//
// Added by the designer: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module keyed_watchdog_timer
  import wdt_pkg::*;
(
  input wire logic clock, // 40 MHz system clock
  input wire logic rst, // power-on reset, async, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [ADR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [DAT_W-1:0] wb_dat_i, // write data
  output logic [DAT_W-1:0] wb_dat_o, // read data
  output logic wb_ack_o, // transfer acknowledge
  input wire logic lowSpeedCrystal, // crystal sub clock pin
  input wire logic lowSpeedInternalRc, // internal rc sub clock
  input wire logic externalResetPinN, // external reset pin, low active
  input wire logic clearWatchdogInstruction, // core pulse
  input wire logic haltInstruction, // core pulse
  input wire logic sleepMode, // core is in sleep or idle
  input wire logic lowVoltageResetFlag, // kept by supply monitor
  input wire logic voltageSelectResetFlag, // kept by supply monitor
  output logic watchdogResetReq, // full reset pulse
  output logic wakeResetReq, // pc and sp reset pulse
  output logic timeoutStatusFlag, // time-out flag
  output logic powerDownFlag // power-down flag
);

  typedef enum logic [1:0] {keyIdle, keyArmed, keyMid, keyLast} key_state_e;

  wdt_count_if cnt ();

  logic [PIN_COUNT-1:0] pinRaw;
  logic [PIN_COUNT-1:0] pinSync;
  logic subSel;
  logic subPrev_reg;
  logic subTick_reg;
  logic [7:0] ctrl_reg;
  logic subCfg_reg;
  logic keyFlag_reg;
  logic timeout_reg;
  logic powerDown_reg;
  logic resetReq_reg;
  logic wakeReq_reg;
  logic ack_reg;
  logic [DAT_W-1:0] rdata_reg;
  logic [DAT_W-1:0] rdata_next;
  key_state_e keyState_reg;
  key_state_e keyState_next;
  logic keyFire;
  logic wdtEnabled;
  logic busTake;
  logic busWrite;
  logic [5:0] regIndex;

  // ==========================================================
  // pin synchronisers
  // all three pins come from outside this clock, so each passes two
  // flops before any logic looks at it
  // the reset pin slot resets to its idle high level so leaving reset clears nothing

  assign pinRaw[PIN_LXT] = lowSpeedCrystal;
  assign pinRaw[PIN_LOW_SPEED_INTERNAL_RC] = lowSpeedInternalRc;
  assign pinRaw[PIN_RESN] = externalResetPinN;

  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : gSync
      logic first_reg;
      logic second_reg;
      // the first flop feeds only the second
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          first_reg <= SYNC_RESET[g];
          second_reg <= SYNC_RESET[g];
        end else begin
          first_reg <= pinRaw[g];
          second_reg <= first_reg;
        end
      end
      assign pinSync[g] = second_reg;
    end
  endgenerate

  // ==========================================================
  // sub clock tick
  // switching source may produce one extra or one lost tick; the
  // watchdog period is coarse so this is accepted
  // limitation: a stopped source gives no ticks, so the watchdog then never fires

  assign subSel = subCfg_reg ? pinSync[PIN_LXT] : pinSync[PIN_LOW_SPEED_INTERNAL_RC];

  // rising edge of the selected sub clock, one system cycle wide
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      subPrev_reg <= 1'b0;
      subTick_reg <= 1'b0;
    end else begin
      subPrev_reg <= subSel;
      subTick_reg <= subSel && !subPrev_reg;
    end
  end

  // ==========================================================
  // counter hook-up

  // only the enable code lets the counter run
  // an invalid key also stops the count; the bad key sequencer takes over from there
  assign wdtEnabled = (ctrl_reg[KEY_HI:KEY_LO] == KEY_ENABLE);

  // every clear source, the pin acts as long as it is held low
  assign cnt.clearCount = clearWatchdogInstruction
    || haltInstruction
    || keyFire
    || !pinSync[PIN_RESN];

  assign cnt.subTick = subTick_reg;
  assign cnt.runCount = wdtEnabled;
  assign cnt.timeoutSelect = ctrl_reg[SEL_HI:SEL_LO];

  sub_clock_counter counter (
    .clock (clock),
    .rst (rst),
    .cnt (cnt.counter)
  );

  // ==========================================================
  // bad key sequencer
  // once armed the reset is committed; a later write of a good key does
  // not call it off, so a glitched key can never escape the reset

  assign keyFire = (keyState_reg == keyLast) && subTick_reg;

  // next state, the third sub clock edge after arming fires, so the reset
  // lands two to three sub periods after the bad key appears
  always_comb begin
    keyState_next = keyState_reg;
    case (keyState_reg)
      keyIdle: begin
        if (keyInvalid(ctrl_reg[KEY_HI:KEY_LO])) begin
          keyState_next = keyArmed;
        end
      end
      keyArmed: begin
        if (subTick_reg) begin
          keyState_next = keyMid;
        end
      end
      keyMid: begin
        if (subTick_reg) begin
          keyState_next = keyLast;
        end
      end
      keyLast: begin
        if (subTick_reg) begin
          keyState_next = keyIdle;
        end
      end
      default: begin
        keyState_next = keyIdle;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      keyState_reg <= keyIdle;
    end else begin
      keyState_reg <= keyState_next;
    end
  end

  // ==========================================================
  // wishbone slave
  // classic single cycle; ack comes one clock after the strobe and
  // drops the clock after, so a held strobe is served again every second clock
  // writes land on the taking edge; the ack a clock later only reports it

  assign busTake = wb_cyc_i && wb_stb_i && !ack_reg;
  assign busWrite = busTake && wb_we_i && wb_sel_i[0];
  assign regIndex = wb_adr_i[ADR_W-1:2];

  // acknowledge, every address answers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= busTake;
    end
  end

  // read mux, unmapped indices read as zero
  always_comb begin
    rdata_next = '0;
    case (regIndex)
      IDX_CTRL: begin
        rdata_next[7:0] = ctrl_reg;
      end
      IDX_FLAGS: begin
        // bits 7..3 of the reset cause word stay zero from the default above
        rdata_next[FLAG_KEY] = keyFlag_reg;
        rdata_next[FLAG_VSEL] = voltageSelectResetFlag;
        rdata_next[FLAG_LV] = lowVoltageResetFlag;
      end
      IDX_SUBCFG: begin
        rdata_next[SUBCFG_SRC] = subCfg_reg;
      end
      IDX_STATUS: begin
        rdata_next[STAT_TO] = timeout_reg;
        rdata_next[STAT_PDF] = powerDown_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  // read data is captured with the ack and held until the next read request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (busTake && !wb_we_i) begin
      rdata_reg <= rdata_next;
    end
  end

  // ==========================================================
  // software registers

  // control register; a fired bad key restores the power-on value so
  // the device does not reset forever
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (keyFire) begin
      ctrl_reg <= CTRL_RESET;
    end else if (busWrite && (regIndex == IDX_CTRL)) begin
      ctrl_reg <= wb_dat_i[7:0];
    end
  end

  // sub clock source select
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      subCfg_reg <= SUBCFG_RESET;
    end else if (busWrite && (regIndex == IDX_SUBCFG)) begin
      subCfg_reg <= wb_dat_i[SUBCFG_SRC];
    end
  end

  // key reset flag, hardware only sets it and the set wins a clash
  // software must write zero once it has handled the event
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      keyFlag_reg <= 1'b0;
    end else if (keyFire) begin
      keyFlag_reg <= 1'b1;
    end else if (busWrite && (regIndex == IDX_FLAGS)) begin
      keyFlag_reg <= wb_dat_i[FLAG_KEY];
    end
  end

  // ==========================================================
  // core status flags

  // time-out flag: any overflow sets it, a halt clears it; set wins
  // keeping it set on a clash means an overflow is never lost
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      timeout_reg <= 1'b0;
    end else if (cnt.overflow) begin
      timeout_reg <= 1'b1;
    end else if (haltInstruction) begin
      timeout_reg <= 1'b0;
    end
  end

  // power-down flag: halt or a sleep overflow sets, clear-watchdog clears
  // a halt and a clear in the same cycle leave the flag set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerDown_reg <= 1'b0;
    end else if (haltInstruction || (cnt.overflow && sleepMode)) begin
      powerDown_reg <= 1'b1;
    end else if (clearWatchdogInstruction) begin
      powerDown_reg <= 1'b0;
    end
  end

  // ==========================================================
  // reset requests
  // both are single pulses; the reset controller widens them as it needs

  // full reset: normal-mode overflow or a fired bad key
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resetReq_reg <= 1'b0;
    end else begin
      resetReq_reg <= (cnt.overflow && !sleepMode) || keyFire;
    end
  end

  // wake reset: overflow while asleep resets only pc and stack pointer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wakeReq_reg <= 1'b0;
    end else begin
      wakeReq_reg <= cnt.overflow && sleepMode;
    end
  end

  // ==========================================================
  // outputs, all straight from flops
  // the reset controller sees only registered pulses, never a raw decode

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign watchdogResetReq = resetReq_reg;
  assign wakeResetReq = wakeReq_reg;
  assign timeoutStatusFlag = timeout_reg;
  assign powerDownFlag = powerDown_reg;

endmodule : keyed_watchdog_timer

// >>> test/wdt_chk.sv
// concurrent checks on the keyed watchdog top-level ports
`timescale 1ns/1ps
module wdt_chk
  import wdt_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [DAT_W-1:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic clearWatchdogInstruction, // core clear
  input wire logic haltInstruction, // core halt
  input wire logic sleepMode, // core asleep
  input wire logic watchdogResetReq, // full reset pulse
  input wire logic wakeResetReq, // wake reset pulse
  input wire logic timeoutStatusFlag, // time-out flag
  input wire logic powerDownFlag // power-down flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================================
  // bus answer and read layout
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged one cycle later");
  a_read_upper: assert property (wb_ack_o && !$past(wb_we_i) |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  // ==========================================================
  // reset requests are single pulses with a known cause
  a_req_pulse: assert property (watchdogResetReq |=> !watchdogResetReq)
    else $error("full reset request longer than one cycle");
  a_wake_pulse: assert property (wakeResetReq |=> !wakeResetReq)
    else $error("wake reset request longer than one cycle");
  a_wake_flags: assert property (wakeResetReq |-> timeoutStatusFlag && powerDownFlag)
    else $error("wake reset without both flags");
  a_wake_asleep: assert property (wakeResetReq |-> $past(sleepMode))
    else $error("wake reset while awake");
  a_timeout_cause: assert property ($rose(timeoutStatusFlag) |-> watchdogResetReq || wakeResetReq)
    else $error("time-out flag rose without a reset request");
  // ==========================================================
  // power-down flag set by halt, cleared by clear-watchdog
  a_halt_flags: assert property (haltInstruction |=> powerDownFlag && !timeoutStatusFlag)
    else $error("halt did not set power-down and clear time-out");
  a_clear_pd: assert property (clearWatchdogInstruction && !haltInstruction |=> !powerDownFlag)
    else $error("clear-watchdog left power-down set");
  a_pd_cause: assert property ($rose(powerDownFlag) |-> $past(haltInstruction) || wakeResetReq)
    else $error("power-down rose without a halt");
endmodule : wdt_chk

bind keyed_watchdog_timer wdt_chk i_chk (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .clearWatchdogInstruction, .haltInstruction, .sleepMode, .watchdogResetReq, .wakeResetReq,
  .timeoutStatusFlag, .powerDownFlag);

// >>> test/core_model.sv
// processor core model issuing clear and halt instructions
`timescale 1ns/1ps
module core_model (
  input wire logic clock, // system clock
  input wire logic rst, // async reset, active high
  input wire logic clearReq, // bench asks for a clear
  input wire logic haltReq, // bench asks for a halt
  input wire logic sleepReq, // halt enters sleep when high
  input wire logic wakeIn, // wake reset from watchdog
  output logic clearWatchdogInstruction, // one-cycle clear
  output logic haltInstruction, // one-cycle halt
  output logic sleepMode // core asleep
);
  // ==========================================================
  // instruction pulses, one clock each as the core executes them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clearWatchdogInstruction <= 1'b0;
      haltInstruction <= 1'b0;
    end else begin
      clearWatchdogInstruction <= clearReq;
      haltInstruction <= haltReq;
    end
  end
  // sleep is left only by a wake reset, so a lost wake leaves the core stuck asleep
  always_ff @(posedge clock or posedge rst) begin
    if (rst) sleepMode <= 1'b0;
    else if (wakeIn) sleepMode <= 1'b0;
    else if (haltReq && sleepReq) sleepMode <= 1'b1;
  end
endmodule : core_model

// >>> test/testbench.sv
// self-checking bench for the keyed watchdog timer
`timescale 1ns/1ps
module testbench;
  import wdt_pkg::*;
  logic clock = 1'b0, rst = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [ADR_W-1:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [DAT_W-1:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic lowSpeedCrystal = 1'b0, lowSpeedInternalRc = 1'b0, externalResetPinN = 1'b1;
  logic lowVoltageResetFlag = 1'b1, voltageSelectResetFlag = 1'b0;
  logic clearReq = 1'b0, haltReq = 1'b0, sleepReq = 1'b0, rcRun = 1'b1, xtRun = 1'b0;
  logic clearWatchdogInstruction, haltInstruction, sleepMode, sawWake;
  logic watchdogResetReq, wakeResetReq, timeoutStatusFlag, powerDownFlag;
  logic [2:0] subDiv = 3'h0;
  int fail_count = 0, checked = 0, n;

  // ==========================================================
  // clocks, design and core model
  always #12.5 clock = ~clock;
  // sub clocks: rc period 4 clocks, crystal 8; a stopped source stays low
  always @(posedge clock) begin
    subDiv <= subDiv + 3'h1;
    lowSpeedInternalRc <= rcRun & subDiv[1];
    lowSpeedCrystal <= xtRun & subDiv[2];
  end
  keyed_watchdog_timer i_dut (.clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .lowSpeedCrystal, .lowSpeedInternalRc, .externalResetPinN, .clearWatchdogInstruction,
    .haltInstruction, .sleepMode, .lowVoltageResetFlag, .voltageSelectResetFlag, .watchdogResetReq,
    .wakeResetReq, .timeoutStatusFlag, .powerDownFlag);
  core_model i_core (.clock, .rst, .clearReq, .haltReq, .sleepReq, .wakeIn(wakeResetReq),
    .clearWatchdogInstruction, .haltInstruction, .sleepMode);

  // ==========================================================
  // comparison, verdict and bus tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // one classic cycle; the request is held until ack is sampled high
  task automatic bus(input logic [7:0] adr, input logic we, input logic [7:0] dat);
    int k;
    k = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      final_report();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : bus
  task automatic rd_check(input string what, input logic [7:0] adr, input logic [31:0] exp);
    bus(adr, 1'b0, 8'h00);
    check(what, rd, exp);
  endtask : rd_check
  task automatic core_op(input logic clr, input logic hlt);
    @(posedge clock);
    clearReq <= clr;
    haltReq <= hlt;
    @(posedge clock);
    clearReq <= 1'b0;
    haltReq <= 1'b0;
  endtask : core_op
  // counts clocks until a reset request or the bound, whichever first
  task automatic wait_req(input int bound, output int cnt);
    cnt = 0;
    while (cnt < bound && watchdogResetReq !== 1'b1 && wakeResetReq !== 1'b1) begin
      @(posedge clock);
      cnt++;
    end
    sawWake = (wakeResetReq === 1'b1);
  endtask : wait_req

  // ==========================================================
  // main sequence
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd_check("control reset", 8'h00, 32'h53);
    rd_check("flags reset", 8'h04, 32'h04);
    rd_check("unmapped read", 8'h10, 32'h0);
    for (int s = 0; s < 3; s++) begin
      bus(8'h00, 1'b1, {KEY_ENABLE, 3'(s)});
      rd_check("control rw", 8'h00, {24'h000000, KEY_ENABLE, 3'(s)});
      core_op(1'b1, 1'b0);
      wait_req(20000, n);
      check("period", 32'(n >= (4 << (8 + 2 * s)) - 8 && n <= (4 << (8 + 2 * s)) + 16), 32'h1);
      rd_check("timeout flag", 8'h0c, 32'h1);
    end
    // crystal source with the rc stopped still times out, at its own rate
    bus(8'h08, 1'b1, 8'h01);
    rcRun <= 1'b0;
    xtRun <= 1'b1;
    bus(8'h00, 1'b1, 8'h50);
    core_op(1'b1, 1'b0);
    wait_req(5000, n);
    check("crystal period", 32'(n >= 2040 && n <= 2064), 32'h1);
    bus(8'h08, 1'b1, 8'h00);
    rcRun <= 1'b1;
    xtRun <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      core_op(1'b1, 1'b0);
      wait_req(600, n);
      check("cleared in time", n, 600);
    end
    externalResetPinN <= 1'b0;
    wait_req(3000, n);
    check("pin low holds", n, 3000);
    externalResetPinN <= 1'b1;
    bus(8'h00, 1'b1, 8'ha8);
    wait_req(3000, n);
    check("disabled", n, 3000);
    bus(8'h00, 1'b1, 8'h50);
    sleepReq <= 1'b1;
    core_op(1'b0, 1'b1);
    rd_check("halt flags", 8'h0c, 32'h2);
    wait_req(2000, n);
    check("wake request", {31'h0, sawWake}, 32'h1);
    check("sleep period", 32'(n >= 1008 && n <= 1040), 32'h1);
    rd_check("wake flags", 8'h0c, 32'h3);
    check("flag pins", {30'h0, powerDownFlag, timeoutStatusFlag}, 32'h3);
    sleepReq <= 1'b0;
    core_op(1'b1, 1'b0);
    bus(8'h0c, 1'b0, 8'h00);
    check("power down cleared", rd & 32'h2, 32'h0);
    check("power down pin", {31'h0, powerDownFlag}, 32'h0);
    bus(8'h00, 1'b1, 8'h00);
    wait_req(100, n);
    // two to three rc periods of four clocks after the write, plus the request flop
    check("bad key delay", 32'(n >= 10 && n <= 14 && !sawWake), 32'h1);
    rd_check("key flag set", 8'h04, 32'h05);
    rd_check("control reloaded", 8'h00, 32'h53);
    voltageSelectResetFlag <= 1'b1;
    repeat (200) @(posedge clock);
    rd_check("key flag kept", 8'h04, 32'h07);
    bus(8'h04, 1'b1, 8'h00);
    rd_check("key flag cleared", 8'h04, 32'h06);
    final_report();
  end
  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    fail_count++;
    final_report();
  end
endmodule : testbench
